// ==== port_pin_defs.svh ====
// offsets, field positions, reset values and timing counts for the port pin block
// assumes inclusion by bare name from the pin control block and the bench
`ifndef PORT_PIN_DEFS_SVH
`define PORT_PIN_DEFS_SVH

// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define IDX_PORT_T_PULL_ENABLE 12'h244
`define IDX_PORT_R_DATA 12'h368
`define IDX_PORT_R_INPUT 12'h369
`define IDX_PORT_R_DIRECTION 12'h36a
`define IDX_PORT_R_PULL_ENABLE 12'h36c
`define IDX_PORT_R_PULL_POLARITY 12'h36d
`define IDX_RESERVED_ZERO 12'h36e
`define IDX_PORT_R_TIMER_ROUTING 12'h36f

// ----------------------------------------------------------------
// fields, reset values, responses, timing
// ----------------------------------------------------------------
`define ROUTE_CH6_BIT 6
`define ROUTE_CH7_BIT 7
`define RESET_BYTE 8'h00
`define RESERVED_READ 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define SYNC_STAGES 2

`endif

// ==== port_pin_pkg.sv ====
// types shared by the port pin block
// assumes the defines header is compiled alongside
package port_pin_pkg;

	// ----------------------------------------------------------------
	// pin drive bundle
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pull_en;
		logic [7:0] pull_down;
	} pin_drive_t;

	// ----------------------------------------------------------------
	// alternative pins for timer channels six and seven
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] out;
		logic [1:0] oe;
	} alt_drive_t;

	typedef enum logic [1:0] {
		WR_IDLE,
		WR_RESP
	} wr_state_t;

endpackage : port_pin_pkg

// ==== pin_sync.sv ====
// multi-stage synchroniser for pin levels, one chain per bit
// assumes one clock and a synchronous active-low reset
module pin_sync #(
	parameter int WIDTH = 8,
	parameter int STAGES = 2
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// levels
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			logic [STAGES-1:0] chain_ff;
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					chain_ff <= '0;
				else
					chain_ff <= {chain_ff[STAGES-2:0], d[i]};
			end
			assign q[i] = chain_ff[STAGES-1];
		end
	endgenerate

endmodule : pin_sync

// ==== port_r_t_pin_control.sv ====
// pin control for port t pull enables and port r direction, pulls and timer routing
// assumes pins and timer signals synchronous to aclk; axi4-lite master with one op of each kind
// Summary of operation
// RULE1: port t pull-enable byte at index 0x244, one bit per pin.
// RULE2: port t pull acts only while that pin is an input.
// RULE3: port t pull enables clear after reset.
// RULE4: port r direction bit one makes output, zero makes input.
// RULE5: enabled output compare forces pin output, stored direction untouched.
// RULE6: compare disabled returns pin direction to stored bit.
// RULE7: input capture always sees the pin level.
// RULE8: data and input readback settle within two clocks after direction change. The code takes three: one in the drive register, two in pin_sync.
// RULE9: polarity bit one pull-down, zero pull-up, only when enabled and input.
// RULE10: reserved index 0x36e reads zero, writes ignored.
// RULE11: routing bit 7 moves timer channel seven to alternative pin seven.
// RULE12: routing bit 6 moves timer channel six to alternative pin six.
// RULE13: all control registers readable and writable anytime.
// RULE14: port r pull uses effective direction including compare override.
// RULE15: undocumented reset values are zero.
//
// Implementation choice: the AXI4-Lite register port.
`include "port_pin_defs.svh"

module port_r_t_pin_control #(
	parameter int ADDR_W = 16
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// port t pins
	input wire logic [7:0] port_t_pin_is_output,
	output logic [7:0] port_t_pull_active,
	// port r pins
	input wire logic [7:0] port_r_pin_in,
	output port_pin_pkg::pin_drive_t port_r_drive,
	// alternative port pins six and seven
	input wire logic [1:0] alt_port_pin_in,
	output port_pin_pkg::alt_drive_t alt_port_drive,
	// timer module channels
	input wire logic [7:0] timer_oc_enable,
	input wire logic [7:0] timer_oc_level,
	output logic [7:0] timer_ic_level
);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] port_t_pull_enable_ff;
	logic [7:0] port_r_data_ff;
	logic [7:0] port_r_direction_ff;
	logic [7:0] port_r_pull_enable_ff;
	logic [7:0] port_r_pull_polarity_ff;
	logic [7:0] port_r_timer_routing_ff;

	// bus state
	logic [ADDR_W-1:0] awaddr_ff;
	logic aw_held_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic w_held_ff;
	port_pin_pkg::wr_state_t wr_state_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;

	// pin side
	logic [7:0] r_on_port_r;
	logic [7:0] r_eff_dir;
	logic [7:0] r_pin_out;
	logic [1:0] alt_routed;
	logic [7:0] r_pin_sync;
	logic [7:0] r_data_read;

	// write decode
	logic wr_fire;
	logic [11:0] wr_idx;
	logic [11:0] rd_idx;
	logic wr_lane0;
	logic [7:0] wr_byte;

	// ----------------------------------------------------------------
	// timer routing and direction
	// ----------------------------------------------------------------
	// route channels six and seven
	assign alt_routed = {port_r_timer_routing_ff[`ROUTE_CH7_BIT], port_r_timer_routing_ff[`ROUTE_CH6_BIT]};

	always_comb
	begin
		r_on_port_r = 8'hff;
		// RULE12: channel six routing
		r_on_port_r[6] = ~alt_routed[0];
		// RULE11: channel seven routing
		r_on_port_r[7] = ~alt_routed[1];
	end

	// RULE4: stored direction drives pin
	// RULE5: compare override forces output
	// RULE6: override drops when compare off
	assign r_eff_dir = port_r_direction_ff | (timer_oc_enable & r_on_port_r);

	always_comb
	begin
		r_pin_out = port_r_data_ff;
		for (int i = 0; i < 8; i++)
		begin
			if (r_on_port_r[i] && timer_oc_enable[i])
				r_pin_out[i] = timer_oc_level[i];
		end
	end

	// port r pin drive from registers and override
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			port_r_drive <= '0;
		else
		begin
			port_r_drive.out <= r_pin_out;
			port_r_drive.oe <= r_eff_dir;
			// RULE14: pull follows effective direction
			port_r_drive.pull_en <= port_r_pull_enable_ff & ~r_eff_dir;
			// RULE9: polarity select when pulled
			port_r_drive.pull_down <= port_r_pull_polarity_ff & port_r_pull_enable_ff & ~r_eff_dir;
		end
	end

	// alternative pins carry the routed timer channels
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			alt_port_drive <= '0;
		else
		begin
			alt_port_drive.out <= timer_oc_level[7:6] & alt_routed;
			alt_port_drive.oe <= timer_oc_enable[7:6] & alt_routed;
		end
	end

	// RULE2: port t pull only on inputs
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			port_t_pull_active <= '0;
		else
			port_t_pull_active <= port_t_pull_enable_ff & ~port_t_pin_is_output;
	end

	// ----------------------------------------------------------------
	// input capture and readback
	// ----------------------------------------------------------------
	// RULE7: capture sees raw pin level
	always_comb
	begin
		timer_ic_level = port_r_pin_in;
		if (alt_routed[0])
			timer_ic_level[6] = alt_port_pin_in[0];
		if (alt_routed[1])
			timer_ic_level[7] = alt_port_pin_in[1];
	end

	// RULE8: two-stage readback synchroniser
	pin_sync #(
		.WIDTH(8),
		.STAGES(`SYNC_STAGES)
	) pin_sync_i (
		.aclk(aclk),
		.aresetn(aresetn),
		.d(port_r_pin_in),
		.q(r_pin_sync)
	);

	// outputs read latch, inputs read pin
	assign r_data_read = (r_eff_dir & port_r_data_ff) | (~r_eff_dir & r_pin_sync);

	// ----------------------------------------------------------------
	// axi4-lite write path
	// ----------------------------------------------------------------
	assign s_axi_awready = ~aw_held_ff & (wr_state_ff == port_pin_pkg::WR_IDLE);
	assign s_axi_wready = ~w_held_ff & (wr_state_ff == port_pin_pkg::WR_IDLE);
	assign s_axi_bvalid = (wr_state_ff == port_pin_pkg::WR_RESP);
	assign s_axi_bresp = bresp_ff;
	assign wr_fire = aw_held_ff & w_held_ff & (wr_state_ff == port_pin_pkg::WR_IDLE);
	assign wr_idx = awaddr_ff[13:2];
	assign wr_lane0 = wstrb_ff[0];
	assign wr_byte = wdata_ff[7:0];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_ff <= 1'b0;
			awaddr_ff <= '0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held_ff <= 1'b1;
			awaddr_ff <= s_axi_awaddr;
		end
		else if (wr_fire)
			aw_held_ff <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held_ff <= 1'b0;
			wdata_ff <= '0;
			wstrb_ff <= '0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held_ff <= 1'b1;
			wdata_ff <= s_axi_wdata;
			wstrb_ff <= s_axi_wstrb;
		end
		else if (wr_fire)
			w_held_ff <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_state_ff <= port_pin_pkg::WR_IDLE;
			bresp_ff <= `RESP_OKAY;
		end
		else
		begin
			case (wr_state_ff)
				port_pin_pkg::WR_IDLE:
				begin
					if (wr_fire)
					begin
						wr_state_ff <= port_pin_pkg::WR_RESP;
						bresp_ff <= idx_known(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
					end
				end
				port_pin_pkg::WR_RESP:
				begin
					if (s_axi_bready)
						wr_state_ff <= port_pin_pkg::WR_IDLE;
				end
				default:
					wr_state_ff <= port_pin_pkg::WR_IDLE;
			endcase
		end
	end

	// RULE13: registers writable anytime
	// RULE3: port t pulls clear at reset
	// RULE15: other registers reset to zero
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			port_t_pull_enable_ff <= `RESET_BYTE;
			port_r_data_ff <= `RESET_BYTE;
			port_r_direction_ff <= `RESET_BYTE;
			port_r_pull_enable_ff <= `RESET_BYTE;
			port_r_pull_polarity_ff <= `RESET_BYTE;
			port_r_timer_routing_ff <= `RESET_BYTE;
		end
		else if (wr_fire && wr_lane0)
		begin
			// RULE10: reserved and input writes dropped
			case (wr_idx)
				// RULE1: port t pull-enable store
				`IDX_PORT_T_PULL_ENABLE: port_t_pull_enable_ff <= wr_byte;
				`IDX_PORT_R_DATA: port_r_data_ff <= wr_byte;
				`IDX_PORT_R_DIRECTION: port_r_direction_ff <= wr_byte;
				`IDX_PORT_R_PULL_ENABLE: port_r_pull_enable_ff <= wr_byte;
				`IDX_PORT_R_PULL_POLARITY: port_r_pull_polarity_ff <= wr_byte;
				`IDX_PORT_R_TIMER_ROUTING: port_r_timer_routing_ff <= wr_byte;
				default:
				begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// address check
	// ----------------------------------------------------------------
	function automatic logic idx_known(input logic [11:0] idx);
		case (idx)
			`IDX_PORT_T_PULL_ENABLE,
			`IDX_PORT_R_DATA,
			`IDX_PORT_R_INPUT,
			`IDX_PORT_R_DIRECTION,
			`IDX_PORT_R_PULL_ENABLE,
			`IDX_PORT_R_PULL_POLARITY,
			`IDX_RESERVED_ZERO,
			`IDX_PORT_R_TIMER_ROUTING: idx_known = 1'b1;
			default: idx_known = 1'b0;
		endcase
	endfunction : idx_known

	// ----------------------------------------------------------------
	// axi4-lite read path
	// ----------------------------------------------------------------
	assign s_axi_arready = ~rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign rd_idx = s_axi_araddr[13:2];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rvalid_ff <= 1'b0;
		else if (s_axi_arvalid && s_axi_arready)
			rvalid_ff <= 1'b1;
		else if (s_axi_rready)
			rvalid_ff <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rdata_ff <= '0;
			rresp_ff <= `RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rresp_ff <= (idx_known(rd_idx) && (s_axi_araddr[ADDR_W-1:14] == '0)) ? `RESP_OKAY : `RESP_SLVERR;
			case (rd_idx)
				`IDX_PORT_T_PULL_ENABLE: rdata_ff <= {24'h000000, port_t_pull_enable_ff};
				// RULE8: data readback after sync
				`IDX_PORT_R_DATA: rdata_ff <= {24'h000000, r_data_read};
				`IDX_PORT_R_INPUT: rdata_ff <= {24'h000000, r_pin_sync};
				`IDX_PORT_R_DIRECTION: rdata_ff <= {24'h000000, port_r_direction_ff};
				`IDX_PORT_R_PULL_ENABLE: rdata_ff <= {24'h000000, port_r_pull_enable_ff};
				`IDX_PORT_R_PULL_POLARITY: rdata_ff <= {24'h000000, port_r_pull_polarity_ff};
				// RULE10: reserved reads zero
				`IDX_RESERVED_ZERO: rdata_ff <= {24'h000000, `RESERVED_READ};
				`IDX_PORT_R_TIMER_ROUTING: rdata_ff <= {24'h000000, port_r_timer_routing_ff};
				default: rdata_ff <= 32'h00000000;
			endcase
		end
	end

endmodule : port_r_t_pin_control

// ==== port_ctl_props.sv ====
// assertions on the top ports of the port pin block
// assumes bind onto port_r_t_pin_control, one clock, reset low
module port_ctl_props #(
	parameter int ADDR_W = 16
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// pins and timer
	input wire logic [7:0] port_t_pin_is_output,
	input wire logic [7:0] port_t_pull_active,
	input wire logic [7:0] port_r_pin_in,
	input wire port_pin_pkg::pin_drive_t port_r_drive,
	input wire logic [1:0] alt_port_pin_in,
	input wire port_pin_pkg::alt_drive_t alt_port_drive,
	input wire logic [7:0] timer_oc_enable,
	input wire logic [7:0] timer_oc_level,
	input wire logic [7:0] timer_ic_level
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence rd_wait;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	reset_clear_a: assert property ($rose(aresetn) |-> port_t_pull_active == 8'h00)
		else $error("pull active after reset");
	port_t_pull_a: assert property ((port_t_pull_active & $past(port_t_pin_is_output)) == 8'h00)
		else $error("pull on output pin");
	oc_force_a: assert property (|timer_oc_enable[5:0] |=>
		(port_r_drive.oe[5:0] & $past(timer_oc_enable[5:0])) == $past(timer_oc_enable[5:0]))
		else $error("compare did not force output");
	pull_dir_a: assert property ((port_r_drive.pull_en & port_r_drive.oe) == 8'h00)
		else $error("pull on driven pin");
	pull_down_a: assert property ((port_r_drive.pull_down & ~port_r_drive.pull_en) == 8'h00)
		else $error("pull-down without pull");
	capture_a: assert property (timer_ic_level[5:0] == port_r_pin_in[5:0])
		else $error("capture not pin level");
	alt_route_a: assert property ((alt_port_drive.oe & ~$past(timer_oc_enable[7:6])) == 2'b00)
		else $error("alt pin driven without compare");
	rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read not answered");
	rd_hold_a: assert property (rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
endmodule : port_ctl_props

// ==== port_pin_model.sv ====
// pin model: resolves port r pin levels from the block's drive
// assumes undriven, unpulled pins follow ext_level from the bench
module port_pin_model (
	// drive from the block
	input wire port_pin_pkg::pin_drive_t drive,
	// outside level on floating pins
	input wire logic [7:0] ext_level,
	// resolved levels
	output logic [7:0] pin_level
);
	timeunit 1ns;
	timeprecision 1ns;
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			if (drive.oe[i])
				pin_level[i] = drive.out[i];
			else if (drive.pull_en[i])
				pin_level[i] = ~drive.pull_down[i];
			else
				pin_level[i] = ext_level[i];
		end
	end
endmodule : port_pin_model

// ==== tb_port_r_t_pin_control.sv ====
// self-checking bench for the port pin block
// assumes defines header, package, block, checker and pin model compiled
`include "port_pin_defs.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; $display("Error %0t: %h vs %h", $time, a, e); end end

module tb_port_r_t_pin_control;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [15:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, alt_port_pin_in;
	logic [7:0] port_t_pin_is_output, port_t_pull_active, port_r_pin_in, ext_level, v;
	logic [7:0] timer_oc_enable, timer_oc_level, timer_ic_level;
	port_pin_pkg::pin_drive_t port_r_drive;
	port_pin_pkg::alt_drive_t alt_port_drive;
	logic [33:0] exp_q[$];
	logic [33:0] exp_v;
	logic [11:0] regs [5] = '{`IDX_PORT_T_PULL_ENABLE, `IDX_PORT_R_DIRECTION, `IDX_PORT_R_PULL_ENABLE,
		`IDX_PORT_R_PULL_POLARITY, `IDX_PORT_R_TIMER_ROUTING};
	int bad_count = 0;
	int n_tests = 0;
	int cyc = 0;
	port_r_t_pin_control #(.ADDR_W(16)) port_r_t_pin_control_i (.*);
	port_pin_model port_pin_model_i (.drive(port_r_drive), .ext_level(ext_level), .pin_level(port_r_pin_in));
	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	function automatic logic [15:0] ba(input logic [11:0] i);
		return {2'b00, i, 2'b00};
	endfunction : ba
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] resp);
		exp_q.push_back({resp, 32'h0});
		s_axi_awaddr <= ba(idx);
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		@(posedge aclk);
		while (s_axi_awvalid || s_axi_wvalid)
		begin
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			@(posedge aclk);
		end
		while (!s_axi_bvalid)
			@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] resp = `RESP_OKAY);
		exp_q.push_back({resp, 24'h0, d});
		s_axi_araddr <= ba(idx);
		s_axi_arvalid <= 1'b1;
		@(posedge aclk);
		while (!s_axi_arready)
			@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid)
			@(posedge aclk);
	endtask : rd
	task automatic settle();
		repeat (2) @(posedge aclk);
	endtask : settle
	// ------------------------------------------------
	// result monitor and timeout
	// ------------------------------------------------
	always @(posedge aclk)
	begin
		cyc++;
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
		begin
			exp_v = exp_q.pop_front();
			`CHK({s_axi_rresp, s_axi_rdata}, exp_v)
		end
		if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
		begin
			exp_v = exp_q.pop_front();
			`CHK({s_axi_bresp, 32'h0}, exp_v)
		end
		if (cyc == 3000)
		begin
			bad_count++;
			print_verdict();
		end
	end
	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial
	begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
		{port_t_pin_is_output, timer_oc_enable, timer_oc_level, ext_level, alt_port_pin_in} = '0;
		v = 8'h5f;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		foreach (regs[i])
			rd(regs[i], `RESET_BYTE);
		foreach (regs[i])
		begin
			v = lfsr(v);
			wr(regs[i], v, `RESP_OKAY);
			rd(regs[i], v);
		end
		wr(`IDX_RESERVED_ZERO, 8'hff, `RESP_OKAY);
		rd(`IDX_RESERVED_ZERO, `RESERVED_READ);
		wr(12'h000, 8'hff, `RESP_SLVERR);
		wr(`IDX_PORT_T_PULL_ENABLE, 8'hff, `RESP_OKAY);
		repeat (8)
		begin
			v = lfsr(v);
			port_t_pin_is_output <= v;
			settle();
			`CHK(port_t_pull_active, ~v)
		end
		wr(`IDX_PORT_R_DIRECTION, 8'h0f, `RESP_OKAY);
		wr(`IDX_PORT_R_PULL_ENABLE, 8'hff, `RESP_OKAY);
		wr(`IDX_PORT_R_PULL_POLARITY, 8'h33, `RESP_OKAY);
		wr(`IDX_PORT_R_TIMER_ROUTING, 8'h00, `RESP_OKAY);
		repeat (8)
		begin
			v = lfsr(v);
			timer_oc_enable <= v;
			settle();
			`CHK(port_r_drive.oe, v | 8'h0f)
			`CHK(port_r_drive.pull_en, ~(v | 8'h0f))
			`CHK(port_r_drive.pull_down, 8'h33 & ~(v | 8'h0f))
		end
		rd(`IDX_PORT_R_DIRECTION, 8'h0f);
		timer_oc_enable <= 8'h00;
		settle();
		`CHK(port_r_drive.oe, 8'h0f)
		wr(`IDX_PORT_R_DIRECTION, 8'h00, `RESP_OKAY);
		wr(`IDX_PORT_R_PULL_ENABLE, 8'h00, `RESP_OKAY);
		v = lfsr(v);
		ext_level <= v;
		repeat (3) @(posedge aclk);
		rd(`IDX_PORT_R_INPUT, v);
		rd(`IDX_PORT_R_DATA, v);
		`CHK(timer_ic_level, v)
		wr(`IDX_PORT_R_TIMER_ROUTING, 8'hc0, `RESP_OKAY);
		alt_port_pin_in <= 2'b10;
		timer_oc_enable <= 8'hc0;
		timer_oc_level <= 8'h80;
		settle();
		`CHK(alt_port_drive, 4'b1011)
		`CHK(port_r_drive.oe[7:6], 2'b00)
		`CHK(timer_ic_level[7:6], 2'b10)
		wr(`IDX_PORT_R_TIMER_ROUTING, 8'h00, `RESP_OKAY);
		settle();
		`CHK(port_r_drive.oe[7:6], 2'b11)
		`CHK(alt_port_drive.oe, 2'b00)
		wr(`IDX_PORT_R_DATA, 8'h3c, `RESP_OKAY);
		settle();
		`CHK(port_r_drive.out, 8'hbc)
		rd(`IDX_PORT_R_DATA, {2'b00, v[5:0]});
		rd(12'h000, 8'h00, `RESP_SLVERR);
		s_axi_wstrb <= 4'h0;
		wr(`IDX_PORT_R_PULL_POLARITY, 8'ha5, `RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		rd(`IDX_PORT_R_PULL_POLARITY, 8'h33);
		s_axi_bready <= 1'b0;
		wr(`IDX_PORT_R_PULL_POLARITY, 8'h5a, `RESP_OKAY);
		s_axi_bready <= 1'b1;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
		rd(`IDX_PORT_R_PULL_POLARITY, 8'h5a);
		s_axi_rready <= 1'b1;
		settle();
		print_verdict();
	end
endmodule : tb_port_r_t_pin_control

bind port_r_t_pin_control port_ctl_props #(.ADDR_W(ADDR_W)) port_ctl_props_i (.*);
